//--- core/lsim_pkg.sv
// constants for the load-switch interrupt mask block
package lsim_pkg;
   // register map
   localparam int LSIM_DATA_W = 8;
   localparam int LSIM_MASK_W = 6;
   localparam logic [7:0] LSIM_MASK_ADDR = 8'h04;
   localparam logic [LSIM_MASK_W-1:0] LSIM_MASK_RESET = 6'h00;
   localparam logic [LSIM_DATA_W-1:0] LSIM_REG_RESET = 8'h00;
   localparam logic [LSIM_DATA_W-1:0] LSIM_UNMAPPED_DATA = 8'h00;
   // field positions inside the mask register
   localparam int LSIM_BIT_SW3_FAULT = 5;
   localparam int LSIM_BIT_SW2_FAULT = 4;
   localparam int LSIM_BIT_SW1_FAULT = 3;
   localparam int LSIM_BIT_SW3_ILIMIT = 2;
   localparam int LSIM_BIT_SW2_ILIMIT = 1;
   localparam int LSIM_BIT_SW1_ILIMIT = 0;
   localparam int LSIM_RSVD_MSB = 7;
   localparam int LSIM_RSVD_LSB = 6;
   localparam logic [1:0] LSIM_RSVD_VALUE = 2'h0;
   // interrupt pin levels
   localparam logic LSIM_IRQ_ASSERTED = 1'b0;
   localparam logic LSIM_IRQ_IDLE = 1'b1;
endpackage

//--- core/lsim_gate_if.sv
// carrier between the mask register and the gating unit
`timescale 1ns/1ps
interface lsim_gate_if;
   import lsim_pkg::*;
   logic [LSIM_MASK_W-1:0] events;
   logic [LSIM_MASK_W-1:0] mask;
   logic [LSIM_MASK_W-1:0] pending;
   logic any_pending;
   modport gate
   (
      input events,
      input mask,
      output pending,
      output any_pending
   );
   modport ctrl
   (
      output events,
      output mask,
      input pending,
      input any_pending
   );
endinterface

//--- core/lsim_gate.sv
// mask gating of load-switch events onto the interrupt request
`timescale 1ns/1ps
module lsim_gate
(
   lsim_gate_if.gate gif
);
   import lsim_pkg::*;

   // a set mask bit removes only the event's path to the pin
   always_comb
   begin
      gif.pending = gif.events & ~gif.mask; // see RULE7 // see RULE8
      gif.any_pending = |gif.pending;
   end
endmodule

//--- core/lsim_top.sv
// load-switch interrupt mask register and interrupt pin driver
`timescale 1ns/1ps

// Operation
// RULE1 - bit 5 is a read/write mask for the third switch fault event.
// RULE2 - bit 4 is a read/write mask for the second switch fault event.
// RULE3 - bit 3 is a read/write mask for the first switch fault event.
// RULE4 - bit 2 is a read/write mask for the third switch current limit.
// RULE5 - bit 1 is a read/write mask for the second switch current limit.
// RULE6 - bit 0 is a read/write mask for the first switch current limit.
// RULE7 - with its mask bit clear, an event pulls the interrupt pin low.
// RULE8 - with its mask bit set, an event has no effect on the pin.
// RULE9 - masking never changes the monitoring of the conditions.
// RULE10 - all six mask bits come out of reset cleared.
// RULE11 - bits 7 and 6 are reserved, read-only and read as zero.
// RULE12 - the register sits at subaddress 4 and resets to zero.
// RULE13 - writes to the reserved bits are dropped and they stay zero.
module lsim_top #
(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [lsim_pkg::LSIM_DATA_W-1:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [lsim_pkg::LSIM_MASK_W-1:0] events_i,
   output logic [lsim_pkg::LSIM_DATA_W-1:0] reg_rdata_o,
   output logic reg_rd_valid_o,
   output logic [lsim_pkg::LSIM_MASK_W-1:0] event_seen_o,
   output logic irq_out_n_o
);
   import lsim_pkg::*;

   // refused at elaboration: address 4 needs at least three bits
   if (ADDR_W < 3)
   begin
      $error("lsim_top: ADDR_W too small to reach the mask register");
   end

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == ADDR_W'(LSIM_MASK_ADDR));
   endfunction

   lsim_gate_if gif ();

   lsim_gate u_gate
   (
      .gif(gif)
   );

   // ---- mask register and read path
   logic [LSIM_MASK_W-1:0] mask_reg;
   logic [LSIM_MASK_W-1:0] mask_next;
   logic [LSIM_DATA_W-1:0] rdata_reg;
   logic [LSIM_DATA_W-1:0] rdata_next;
   logic rd_valid_reg;
   logic rd_valid_next;
   logic wr_hit;
   logic rd_hit;

   assign wr_hit = reg_wr_i && addr_hit(reg_addr_i); // see RULE12
   assign rd_hit = reg_rd_i && addr_hit(reg_addr_i); // see RULE12

   always_comb
   begin
      mask_next = mask_reg;
      rdata_next = rdata_reg;
      rd_valid_next = 1'b0;
      if (wr_hit)
      begin
         // write data bits 7 and 6 dropped: reserved bits hold no storage
         mask_next = reg_wdata_i[LSIM_MASK_W-1:0]; // see RULE13
         mask_next[LSIM_BIT_SW3_FAULT] =
            reg_wdata_i[LSIM_BIT_SW3_FAULT]; // see RULE1
         mask_next[LSIM_BIT_SW2_FAULT] =
            reg_wdata_i[LSIM_BIT_SW2_FAULT]; // see RULE2
         mask_next[LSIM_BIT_SW1_FAULT] =
            reg_wdata_i[LSIM_BIT_SW1_FAULT]; // see RULE3
         mask_next[LSIM_BIT_SW3_ILIMIT] =
            reg_wdata_i[LSIM_BIT_SW3_ILIMIT]; // see RULE4
         mask_next[LSIM_BIT_SW2_ILIMIT] =
            reg_wdata_i[LSIM_BIT_SW2_ILIMIT]; // see RULE5
         mask_next[LSIM_BIT_SW1_ILIMIT] =
            reg_wdata_i[LSIM_BIT_SW1_ILIMIT]; // see RULE6
      end
      if (reg_rd_i)
      begin
         rd_valid_next = 1'b1;
         // read shows the stored mask, not a write of the same cycle
         if (rd_hit)
         begin
            rdata_next = {LSIM_RSVD_VALUE, mask_reg}; // see RULE11
         end
         else
         begin
            rdata_next = LSIM_UNMAPPED_DATA;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         mask_reg <= LSIM_MASK_RESET; // see RULE10
         rdata_reg <= LSIM_REG_RESET; // see RULE12
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   // ---- event monitor and interrupt pin
   logic [LSIM_MASK_W-1:0] seen_reg;
   logic [LSIM_MASK_W-1:0] seen_next;
   logic irq_n_reg;
   logic irq_n_next;

   assign gif.events = events_i;
   assign gif.mask = mask_reg;

   always_comb
   begin
      // monitor path never looks at the mask
      seen_next = events_i; // see RULE9
      irq_n_next = gif.any_pending ? LSIM_IRQ_ASSERTED
                                   : LSIM_IRQ_IDLE; // see RULE7 // see RULE8
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         seen_reg <= LSIM_MASK_RESET;
         irq_n_reg <= LSIM_IRQ_IDLE;
      end
      else
      begin
         seen_reg <= seen_next;
         irq_n_reg <= irq_n_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign reg_rd_valid_o = rd_valid_reg;
   assign event_seen_o = seen_reg;
   assign irq_out_n_o = irq_n_reg;

   // ---- checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence mask_write_s;
      wr_hit;
   endsequence

   sequence mask_read_s;
      rd_hit ##1 reg_rd_valid_o;
   endsequence

   sw3_fault_wr_a: assert property ( // see RULE1
      mask_write_s |=> mask_reg[LSIM_BIT_SW3_FAULT] ==
         $past(reg_wdata_i[LSIM_BIT_SW3_FAULT]))
      else $error("third switch fault mask not written");

   sw2_fault_wr_a: assert property ( // see RULE2
      mask_write_s |=> mask_reg[LSIM_BIT_SW2_FAULT] ==
         $past(reg_wdata_i[LSIM_BIT_SW2_FAULT]))
      else $error("second switch fault mask not written");

   sw1_fault_wr_a: assert property ( // see RULE3
      mask_write_s |=> mask_reg[LSIM_BIT_SW1_FAULT] ==
         $past(reg_wdata_i[LSIM_BIT_SW1_FAULT]))
      else $error("first switch fault mask not written");

   sw3_ilimit_wr_a: assert property ( // see RULE4
      mask_write_s |=> mask_reg[LSIM_BIT_SW3_ILIMIT] ==
         $past(reg_wdata_i[LSIM_BIT_SW3_ILIMIT]))
      else $error("third switch limit mask not written");

   sw2_ilimit_wr_a: assert property ( // see RULE5
      mask_write_s |=> mask_reg[LSIM_BIT_SW2_ILIMIT] ==
         $past(reg_wdata_i[LSIM_BIT_SW2_ILIMIT]))
      else $error("second switch limit mask not written");

   sw1_ilimit_wr_a: assert property ( // see RULE6
      mask_write_s |=> mask_reg[LSIM_BIT_SW1_ILIMIT] ==
         $past(reg_wdata_i[LSIM_BIT_SW1_ILIMIT]))
      else $error("first switch limit mask not written");

   mask_hold_a: assert property ( // see RULE12
      !wr_hit |=> $stable(mask_reg))
      else $error("mask changed without a write to its address");

   unmasked_pull_a: assert property ( // see RULE7
      |(events_i & ~mask_reg) |=> irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("unmasked event did not pull the pin low");

   masked_quiet_a: assert property ( // see RULE8
      (events_i & ~mask_reg) == '0 |=> irq_out_n_o == LSIM_IRQ_IDLE)
      else $error("masked event reached the pin");

   monitor_free_a: assert property ( // see RULE9
      ##1 event_seen_o == $past(events_i))
      else $error("monitor output differs from the events");

   reset_clear_a: assert property ( // see RULE10
      @(posedge clk_sys_i) $fell(rst_i) |->
         mask_reg == '0 && irq_out_n_o == LSIM_IRQ_IDLE)
      else $error("mask not cleared by reset");

   rsvd_zero_a: assert property ( // see RULE11
      reg_rd_valid_o |-> reg_rdata_o[LSIM_RSVD_MSB:LSIM_RSVD_LSB] ==
         LSIM_RSVD_VALUE)
      else $error("reserved bits read as non-zero");

   read_back_a: assert property ( // see RULE12
      rd_hit |=> reg_rd_valid_o &&
         reg_rdata_o[LSIM_MASK_W-1:0] == $past(mask_reg))
      else $error("mask read did not return the stored value");

   unmapped_read_a: assert property ( // see RULE12
      reg_rd_i && !rd_hit |=> reg_rdata_o == LSIM_UNMAPPED_DATA)
      else $error("unmapped read returned data");

   rsvd_write_a: assert property ( // see RULE13
      (wr_hit && reg_wdata_i[LSIM_RSVD_MSB:LSIM_RSVD_LSB] != '0) ##2
         mask_read_s |->
         reg_rdata_o[LSIM_RSVD_MSB:LSIM_RSVD_LSB] == LSIM_RSVD_VALUE)
      else $error("reserved write bits came back on read");

   write_drop_a: assert property ( // see RULE13
      wr_hit |=> mask_reg == $past(reg_wdata_i[LSIM_MASK_W-1:0]))
      else $error("mask write did not keep only the low bits");

   sw3_fault_pull_a: assert property ( // see RULE1
      events_i[LSIM_BIT_SW3_FAULT] && !mask_reg[LSIM_BIT_SW3_FAULT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("third switch fault did not reach the pin");

   sw2_fault_pull_a: assert property ( // see RULE2
      events_i[LSIM_BIT_SW2_FAULT] && !mask_reg[LSIM_BIT_SW2_FAULT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("second switch fault did not reach the pin");

   sw1_fault_pull_a: assert property ( // see RULE3
      events_i[LSIM_BIT_SW1_FAULT] && !mask_reg[LSIM_BIT_SW1_FAULT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("first switch fault did not reach the pin");

   sw3_ilimit_pull_a: assert property ( // see RULE4
      events_i[LSIM_BIT_SW3_ILIMIT] && !mask_reg[LSIM_BIT_SW3_ILIMIT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("third switch limit did not reach the pin");

   sw2_ilimit_pull_a: assert property ( // see RULE5
      events_i[LSIM_BIT_SW2_ILIMIT] && !mask_reg[LSIM_BIT_SW2_ILIMIT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("second switch limit did not reach the pin");

   sw1_ilimit_pull_a: assert property ( // see RULE6
      events_i[LSIM_BIT_SW1_ILIMIT] && !mask_reg[LSIM_BIT_SW1_ILIMIT] |=>
         irq_out_n_o == LSIM_IRQ_ASSERTED)
      else $error("first switch limit did not reach the pin");

   all_masked_a: assert property ( // see RULE8
      mask_reg == '1 |=> irq_out_n_o == LSIM_IRQ_IDLE)
      else $error("fully masked register let the pin fall");

   monitor_reset_a: assert property ( // see RULE9
      $fell(rst_i) |-> event_seen_o == '0)
      else $error("monitor output not cleared by reset");

   reset_outputs_a: assert property ( // see RULE12
      $fell(rst_i) |-> reg_rdata_o == LSIM_REG_RESET && !reg_rd_valid_o)
      else $error("read port not cleared by reset");

   rd_valid_set_a: assert property ( // see RULE12
      reg_rd_i |=> reg_rd_valid_o)
      else $error("read strobe gave no valid pulse");

   rd_valid_drop_a: assert property ( // see RULE12
      !reg_rd_i |=> !reg_rd_valid_o)
      else $error("valid pulse without a read strobe");

   rdata_hold_a: assert property ( // see RULE12
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");

endmodule

//--- tb/lsim_host.sv
// host model that drives the register strobes of the mask block
`timescale 1ns/1ps
module lsim_host
(
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rd_valid_i,
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   output logic rd_o
);
   initial
   begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // released lines flip so stale values never pass for a match
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      n = 0;
      d = 'x;
      while (n < 4)
      begin
         @(posedge clk_i);
         n++;
         if (rd_valid_i === 1'b1)
         begin
            d = rdata_i;
            n = 4;
         end
      end
   endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the load-switch interrupt mask block
`timescale 1ns/1ps
module tb;
   import lsim_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] events = 6'h00;
   logic [7:0] addr, wdata, rdata, got;
   logic wr, rd, rd_valid, irq_n;
   logic [5:0] seen;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;

   lsim_host host
   (
      .clk_i(clk_sys_i),
      .rdata_i(rdata),
      .rd_valid_i(rd_valid),
      .addr_o(addr),
      .wr_o(wr),
      .wdata_o(wdata),
      .rd_o(rd)
   );

   lsim_top #(.ADDR_W(8)) DUT
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .reg_addr_i(addr),
      .reg_wr_i(wr),
      .reg_wdata_i(wdata),
      .reg_rd_i(rd),
      .events_i(events),
      .reg_rdata_o(rdata),
      .reg_rd_valid_o(rd_valid),
      .event_seen_o(seen),
      .irq_out_n_o(irq_n)
   );

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string m);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // events change at an edge, then the registered pin settles
   task automatic ev(input logic [5:0] v);
      @(posedge clk_sys_i);
      events <= v;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask

   always @(posedge clk_sys_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         $display("Error %0t: run hung", $time);
         report_and_stop();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      host.rd(LSIM_MASK_ADDR, got);
      chk(got, LSIM_REG_RESET, "mask reset");
      host.wr(LSIM_MASK_ADDR, 8'hff);
      host.rd(LSIM_MASK_ADDR, got);
      chk(got, 8'h3f, "reserved bits");
      host.rd(8'h05, got);
      chk(got, LSIM_UNMAPPED_DATA, "unmapped read");
      for (int i = 0; i < 6; i++)
      begin
         host.wr(LSIM_MASK_ADDR, 8'h3f ^ (8'h01 << i));
         host.rd(LSIM_MASK_ADDR, got);
         chk(got, 8'h3f ^ (8'h01 << i), "mask bit");
         ev(6'h01 << i);
         chk({7'h00, irq_n}, 8'h00, "unmasked event");
         ev(6'h3f ^ (6'h01 << i));
         chk({7'h00, irq_n}, 8'h01, "masked events");
         chk({2'h0, seen}, {2'h0, 6'h3f ^ (6'h01 << i)},
             "monitor");
         ev(6'h00);
         chk({7'h00, irq_n}, 8'h01, "irq released");
      end
      // second reset in mid-run with every bit set
      host.wr(LSIM_MASK_ADDR, 8'h3f);
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      ev(6'h01);
      chk({7'h00, irq_n}, 8'h00, "mask after reset");
      host.rd(LSIM_MASK_ADDR, got);
      chk(got, LSIM_REG_RESET, "mask read after reset");
      report_and_stop();
   end
endmodule
